// ### src/ufc_dev.sv
// ufc_dev: bridge uart end with rts/cts and xon/xoff flow control.
// assumes software drives the register port; fifos stand in for the
// host-side receive and transmit buffers.
module ufc_dev
	import ufc_pkg::*;
(
	input wire logic ref_clk, // system clock
	input wire logic rst_n, // async reset, active low
	ufc_link_if.dev link, // serial link to far end
	input wire logic [7:0] addr, // register byte address
	input wire logic [31:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [31:0] rdata // read data, cycle after rd
);
	logic [4:0] ctrl_r;
	logic [7:0] xon_ch_r, xoff_ch_r, err_ch_r;
	logic [LVL_W-1:0] xon_lim_r, xoff_lim_r;
	logic [19:0] div_r;
	logic [7:0] rxm [FIFO_DEPTH];
	logic [7:0] txm [FIFO_DEPTH];
	logic [PTR_W-1:0] rx_wp_r, rx_rp_r, tx_wp_r, tx_rp_r;
	logic [LVL_W-1:0] rx_lvl_r, tx_lvl_r;
	logic flow_stop_r, halted_r, ovf_r;
	logic pend_r, pend_xoff_r, imm_pend_r;
	logic [7:0] imm_r;
	logic tx_go_r;
	logic [7:0] tx_byte_r;
	logic tx_busy, rx_valid, rx_ferr;
	logic [7:0] rx_byte;
	logic [LVL_W-1:0] eff_xon, eff_xoff, stop_lvl;
	logic hw_en, sw_en, cts_hold, rx_push, rx_pop, tx_push, tx_pop;
	logic send_flow, send_imm, is_flow, wr_status;
	logic [7:0] rx_wbyte;

	assign hw_en = ctrl_r[CB_HW];
	assign sw_en = ctrl_r[CB_SW];

	// limit sanitising; the stored values stay as written so software
	// reads back what it programmed
	always_comb
	begin
		eff_xon = xon_lim_r;
		eff_xoff = xoff_lim_r;
		if (xon_lim_r > FIFO_FULL || xoff_lim_r > FIFO_FULL)
		begin
			eff_xon = XON_LIM_BAD;
			eff_xoff = XOFF_LIM_BAD;
		end
		else if (xoff_lim_r == 10'h000)
			eff_xoff = XOFF_LIM_ZERO;
		stop_lvl = FIFO_FULL - eff_xoff;
		if (eff_xon >= stop_lvl)
			eff_xon = stop_lvl - 10'h001;
	end

	// configuration registers, writable at any time
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			ctrl_r <= CTRL_RST;
			xon_ch_r <= XON_RST;
			xoff_ch_r <= XOFF_RST;
			err_ch_r <= ERR_RST;
			xon_lim_r <= XON_LIM_RST;
			xoff_lim_r <= XOFF_LIM_RST;
			div_r <= DIV_RST;
		end
		else if (wr)
			case (addr)
				OFS_CTRL: ctrl_r <= wdata[4:0];
				OFS_CHARS:
				begin
					xon_ch_r <= wdata[7:0];
					xoff_ch_r <= wdata[15:8];
					err_ch_r <= wdata[23:16];
				end
				OFS_LIMITS:
				begin
					xon_lim_r <= wdata[9:0];
					xoff_lim_r <= wdata[25:16];
				end
				OFS_BAUD: div_r <= (wdata[19:0] == 20'h0) ? 20'h1 : wdata[19:0];
				default: ;
			endcase

	// receive side: flow characters are consumed when software flow is on
	assign is_flow = sw_en && (rx_byte == xon_ch_r || rx_byte == xoff_ch_r);
	// error character only goes in when the fifo has room for it
	assign rx_wbyte = (rx_ferr && ctrl_r[CB_ERRINS]) ? err_ch_r : rx_byte;
	assign rx_push = rx_valid && !is_flow && rx_lvl_r != FIFO_FULL;
	assign rx_pop = rd && addr == OFS_RXDATA && rx_lvl_r != 10'h000;

	always_ff @(posedge ref_clk)
		if (rx_push)
			rxm[rx_wp_r] <= rx_wbyte;

	// receive fifo pointers and level; overflow flag is sticky
	assign wr_status = wr && addr == OFS_STATUS && wdata[SB_OVF];
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			rx_wp_r <= '0;
			rx_rp_r <= '0;
			rx_lvl_r <= '0;
			ovf_r <= 1'b0;
		end
		else
		begin
			if (rx_push)
				rx_wp_r <= rx_wp_r + 9'h1;
			if (rx_pop)
				rx_rp_r <= rx_rp_r + 9'h1;
			rx_lvl_r <= rx_lvl_r + {9'h0, rx_push} - {9'h0, rx_pop};
			// set wins over the write-one clear
			if (rx_valid && !is_flow && rx_lvl_r == FIFO_FULL)
				ovf_r <= 1'b1;
			else if (wr_status)
				ovf_r <= 1'b0;
		end

	// stop/resume hysteresis on the receive fill level
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			flow_stop_r <= 1'b0;
		else if (rx_lvl_r >= stop_lvl)
			flow_stop_r <= 1'b1;
		else if (rx_lvl_r <= eff_xon)
			flow_stop_r <= 1'b0;

	// rts: flow mode wins over transmit-active mode; the latter is cut
	// off at slow baud rates where its timing cannot be kept
	always_comb
		if (hw_en)
			link.rts_n = flow_stop_r;
		else if (ctrl_r[CB_TXRTS] && div_r <= DIV_LOW)
			link.rts_n = !(tx_busy || tx_go_r);
		else
			link.rts_n = 1'b0;

	// halted by a received xoff until the far end sends xon or software flow is switched off
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			halted_r <= 1'b0;
		else if (!sw_en)
			halted_r <= 1'b0;
		else if (rx_valid && rx_byte == xoff_ch_r)
			halted_r <= 1'b1;
		else if (rx_valid && rx_byte == xon_ch_r)
			halted_r <= 1'b0;

	// transmit selection: flow char, then immediate char, then fifo.
	// checking cts only before each immediate or fifo start leaves at most
	// the byte in flight after cts rises; flow chars do not wait for cts
	assign cts_hold = hw_en && link.cts_n;
	assign send_flow = pend_r && (!halted_r || ctrl_r[CB_PASS]);
	assign send_imm = !send_flow && imm_pend_r && !halted_r && !cts_hold;
	assign tx_pop = !tx_busy && !tx_go_r && !send_flow && !send_imm &&
		tx_lvl_r != 10'h000 && !halted_r && !cts_hold;
	assign tx_push = wr && addr == OFS_TXDATA && tx_lvl_r != FIFO_FULL;

	always_ff @(posedge ref_clk)
		if (tx_push)
			txm[tx_wp_r] <= wdata[7:0];

	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			tx_wp_r <= '0;
			tx_rp_r <= '0;
			tx_lvl_r <= '0;
		end
		else
		begin
			if (tx_push)
				tx_wp_r <= tx_wp_r + 9'h1;
			if (tx_pop)
				tx_rp_r <= tx_rp_r + 9'h1;
			tx_lvl_r <= tx_lvl_r + {9'h0, tx_push} - {9'h0, tx_pop};
		end

	// start pulse and byte for the serializer
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			tx_go_r <= 1'b0;
			tx_byte_r <= '0;
		end
		else
		begin
			tx_go_r <= 1'b0;
			if (!tx_busy && !tx_go_r)
			begin
				if (send_flow)
				begin
					tx_go_r <= 1'b1;
					tx_byte_r <= pend_xoff_r ? xoff_ch_r : xon_ch_r;
				end
				else if (send_imm)
				begin
					tx_go_r <= 1'b1;
					tx_byte_r <= imm_r;
				end
				else if (tx_pop)
				begin
					tx_go_r <= 1'b1;
					tx_byte_r <= txm[tx_rp_r];
				end
			end
		end

	// pending xon/xoff follows edges of the stop state; a new edge in
	// the cycle the old one is sent wins over the clear
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			pend_r <= 1'b0;
			pend_xoff_r <= 1'b0;
		end
		else if (!sw_en)
			pend_r <= 1'b0;
		else if (rx_lvl_r >= stop_lvl && !flow_stop_r)
		begin
			pend_r <= 1'b1;
			pend_xoff_r <= 1'b1;
		end
		else if (rx_lvl_r <= eff_xon && flow_stop_r)
		begin
			pend_r <= 1'b1;
			pend_xoff_r <= 1'b0;
		end
		else if (!tx_busy && !tx_go_r && send_flow)
			pend_r <= 1'b0;

	// immediate character slot; a new write replaces an unsent one
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			imm_pend_r <= 1'b0;
			imm_r <= '0;
		end
		else if (wr && addr == OFS_IMM)
		begin
			imm_pend_r <= 1'b1;
			imm_r <= wdata[7:0];
		end
		else if (!tx_busy && !tx_go_r && send_imm)
			imm_pend_r <= 1'b0;

	// register read data, valid the cycle after rd only
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			rdata <= '0;
		else if (!rd)
			rdata <= '0;
		else
			case (addr)
				OFS_CTRL: rdata <= {27'h0, ctrl_r};
				OFS_CHARS: rdata <= {8'h0, err_ch_r, xoff_ch_r, xon_ch_r};
				OFS_LIMITS: rdata <= {6'h0, xoff_lim_r, 6'h0, xon_lim_r};
				OFS_BAUD: rdata <= {12'h0, div_r};
				OFS_RXDATA: rdata <= {23'h0, rx_pop, rx_pop ? rxm[rx_rp_r] : 8'h00};
				OFS_STATUS: rdata <= {2'h0, imm_pend_r, ovf_r, halted_r,
					link.rts_n, tx_lvl_r, 6'h0, rx_lvl_r};
				default: rdata <= '0;
			endcase

	ufc_phy ufc_phy_inst (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.div(div_r),
		.tx_go(tx_go_r),
		.tx_byte(tx_byte_r),
		.tx_busy(tx_busy),
		.txd(link.dev_txd),
		.rxd(link.ext_txd),
		.rx_valid(rx_valid),
		.rx_byte(rx_byte),
		.rx_ferr(rx_ferr)
	);
endmodule : ufc_dev

// ### src/ufc_pkg.sv
// ufc_pkg: constants shared by both ends of the flow-controlled uart link.
// assumes one 100 MHz clock and 8N1 framing on the serial lines.
// How it works
// - rts low while rx fill below stop level
// - rts high once rx fill reaches stop level
// - rts stays high until drained to resume level
// - stop and resume levels live in registers
// - rts/cts only when hardware flow enabled
// - rts follows transmitter; not below 300 baud
// - far end raises cts; at most two more bytes
// - xon and xoff codes are software programmable
// - received xoff halts all transmission, even own xoff
// - pass-through lets own xon/xoff out while halted
// - data resumes only after far end sends xon or software flow is switched off
// - software flow shares levels, changeable any time
// - limit above 512 gives xon 192, xoff 64
// - xon limit clamped below xoff crossing point
// - xoff limit zero replaced by 64
// - host should keep limit sum under 512
// - stop at stop level, continue at resume level
// - far end uses flow control above 1 MBaud
// - error character inserted only with free space
// - immediate character jumps ahead of tx fifo
package ufc_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int DEF_BAUD = 115_200;
	localparam int MIN_TXRTS_BAUD = 300;
	localparam logic [19:0] DIV_RST = 20'(CLK_HZ / DEF_BAUD);
	localparam logic [19:0] DIV_LOW = 20'(CLK_HZ / MIN_TXRTS_BAUD);
	// fifo geometry
	localparam int FIFO_DEPTH = 512;
	localparam int PTR_W = 9;
	localparam int LVL_W = 10;
	localparam logic [LVL_W-1:0] FIFO_FULL = 10'h200;
	// limits: xon limit is a fill level, xoff limit is free bytes at stop
	localparam logic [LVL_W-1:0] XON_LIM_RST = 10'h180;
	localparam logic [LVL_W-1:0] XOFF_LIM_RST = 10'h040;
	localparam logic [LVL_W-1:0] XON_LIM_BAD = 10'h0c0;
	localparam logic [LVL_W-1:0] XOFF_LIM_BAD = 10'h040;
	localparam logic [LVL_W-1:0] XOFF_LIM_ZERO = 10'h040;
	localparam logic [7:0] XON_RST = 8'h11;
	localparam logic [7:0] XOFF_RST = 8'h13;
	localparam logic [7:0] ERR_RST = 8'h00;
	// register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CHARS = 8'h04;
	localparam logic [7:0] OFS_LIMITS = 8'h08;
	localparam logic [7:0] OFS_BAUD = 8'h0c;
	localparam logic [7:0] OFS_TXDATA = 8'h10;
	localparam logic [7:0] OFS_IMM = 8'h14;
	localparam logic [7:0] OFS_RXDATA = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	// ctrl bits
	localparam int CB_HW = 0;
	localparam int CB_SW = 1;
	localparam int CB_PASS = 2;
	localparam int CB_TXRTS = 3;
	localparam int CB_ERRINS = 4;
	localparam logic [4:0] CTRL_RST = 5'h00;
	// status bits above the two levels
	localparam int SB_RTS = 26;
	localparam int SB_HALT = 27;
	localparam int SB_OVF = 28;
	localparam int SB_IMM = 29;
endpackage : ufc_pkg

// ### src/ufc_link_if.sv
// ufc_link_if: serial data and rts/cts wires between the two ends.
// assumes both ends run on the same clock; no clocking block.
interface ufc_link_if;
	logic dev_txd; // device transmit, idle high
	logic ext_txd; // far end transmit, idle high
	logic rts_n; // device ready, active low
	logic cts_n; // far end ready, active low
	modport dev (output dev_txd, output rts_n, input ext_txd, input cts_n);
	modport ext (input dev_txd, input rts_n, output ext_txd, output cts_n);
endinterface : ufc_link_if

// ### src/ufc_phy.sv
// ufc_phy: 8N1 byte transmitter and receiver with a shared bit divider.
// assumes rxd is already synchronous to ref_clk.
module ufc_phy
	import ufc_pkg::*;
(
	input wire logic ref_clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic [19:0] div, // clocks per bit
	input wire logic tx_go, // start a byte, one cycle
	input wire logic [7:0] tx_byte, // byte to send
	output logic tx_busy, // high while a frame is on the line
	output logic txd, // serial out
	input wire logic rxd, // serial in
	output logic rx_valid, // byte received, one cycle
	output logic [7:0] rx_byte, // received byte
	output logic rx_ferr // stop bit was low, with rx_valid
);
	logic [19:0] tcnt_r;
	logic [3:0] tbit_r;
	logic [8:0] tsh_r;
	logic [19:0] rcnt_r;
	logic [3:0] rbit_r;
	logic [8:0] rsh_r;
	logic rbusy_r;

	// transmitter: start bit, eight data bits lsb first, stop bit
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			tx_busy <= 1'b0;
			txd <= 1'b1;
			tcnt_r <= '0;
			tbit_r <= '0;
			tsh_r <= '1;
		end
		else if (!tx_busy)
		begin
			if (tx_go)
			begin
				tx_busy <= 1'b1;
				txd <= 1'b0;
				tsh_r <= {1'b1, tx_byte};
				tcnt_r <= div - 20'h1;
				tbit_r <= 4'h0;
			end
		end
		else if (tcnt_r != 20'h0)
			tcnt_r <= tcnt_r - 20'h1;
		else if (tbit_r == 4'h9)
			tx_busy <= 1'b0;
		else
		begin
			txd <= tsh_r[0];
			tsh_r <= {1'b1, tsh_r[8:1]};
			tbit_r <= tbit_r + 4'h1;
			tcnt_r <= div - 20'h1;
		end

	// receiver: sample each bit in its middle, half a bit after the edge
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			rbusy_r <= 1'b0;
			rcnt_r <= '0;
			rbit_r <= '0;
			rsh_r <= '0;
			rx_valid <= 1'b0;
			rx_byte <= '0;
			rx_ferr <= 1'b0;
		end
		else
		begin
			rx_valid <= 1'b0;
			if (!rbusy_r)
			begin
				if (!rxd)
				begin
					rbusy_r <= 1'b1;
					rcnt_r <= {1'b0, div[19:1]};
					rbit_r <= 4'h0;
				end
			end
			else if (rcnt_r != 20'h0)
				rcnt_r <= rcnt_r - 20'h1;
			else
			begin
				rcnt_r <= div - 20'h1;
				rbit_r <= rbit_r + 4'h1;
				rsh_r <= {rxd, rsh_r[8:1]};
				if (rbit_r == 4'h0 && rxd)
					rbusy_r <= 1'b0; // glitch, not a start bit
				else if (rbit_r == 4'h9)
				begin
					rbusy_r <= 1'b0;
					rx_valid <= 1'b1;
					rx_byte <= rsh_r[8:1];
					rx_ferr <= !rxd;
				end
			end
		end
endmodule : ufc_phy

// ### src/ufc_ext.sv
// ufc_ext: far-end uart that honours rts and xon/xoff and drives cts.
// assumes its user logic sets the same baud divider as the device.
module ufc_ext
	import ufc_pkg::*;
(
	input wire logic ref_clk, // system clock
	input wire logic rst_n, // async reset, active low
	ufc_link_if.ext link, // serial link to device
	input wire logic hw_en, // obey rts
	input wire logic sw_en, // obey xon/xoff
	input wire logic [7:0] xon_ch, // xon code
	input wire logic [7:0] xoff_ch, // xoff code
	input wire logic [19:0] div, // clocks per bit
	input wire logic near_full, // own receiver nearly full
	input wire logic [7:0] tx_data, // byte to send
	input wire logic tx_valid, // byte offered
	output logic tx_ready, // byte taken this cycle
	output logic [7:0] rx_data, // received byte
	output logic rx_valid, // received byte strobe
	output logic held // stopped by device xoff
);
	logic tx_busy, go_r, rv;
	logic [7:0] rb;
	logic [7:0] byte_r;

	// far end flags its own near-full state on cts
	assign link.cts_n = near_full;
	// with hw_en set, a new byte starts only when the device is ready
	assign tx_ready = tx_valid && !tx_busy && !go_r && !held &&
		!(hw_en && link.rts_n);

	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			go_r <= 1'b0;
			byte_r <= '0;
		end
		else
		begin
			go_r <= tx_ready;
			if (tx_ready)
				byte_r <= tx_data;
		end

	// device xoff halts, device xon releases
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			held <= 1'b0;
		else if (!sw_en)
			held <= 1'b0;
		else if (rv && rb == xoff_ch)
			held <= 1'b1;
		else if (rv && rb == xon_ch)
			held <= 1'b0;

	// received bytes pass to the user, flow codes included
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			rx_valid <= 1'b0;
			rx_data <= '0;
		end
		else
		begin
			rx_valid <= rv;
			if (rv)
				rx_data <= rb;
		end

	ufc_phy ufc_phy_inst (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.div(div),
		.tx_go(go_r),
		.tx_byte(byte_r),
		.tx_busy(tx_busy),
		.txd(link.ext_txd),
		.rxd(link.dev_txd),
		.rx_valid(rv),
		.rx_byte(rb),
		.rx_ferr()
	);
endmodule : ufc_ext

// ### sim/ufc_chk.sv
// ufc_chk: wire-level checks on the link between the two uart ends.
// assumes both ends send 8N1 frames at BIT clocks per bit, BIT >= 8.
module ufc_chk
#(
	parameter int BIT = 8 // clocks per bit on both ends
)
(
	input wire logic ref_clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic dev_txd, // device serial out
	input wire logic ext_txd, // far end serial out
	input wire logic rts_n, // device ready, active low
	input wire logic cts_n // far end ready, active low
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] LAST = 16'(10 * BIT - 1);
	localparam logic [15:0] MID_STOP = 16'(9 * BIT + BIT / 2);
	localparam logic [15:0] BITW = 16'(BIT);
	logic dev_in_r, ext_in_r, dev_go, ext_go;
	logic [15:0] dev_cyc_r, ext_cyc_r;
	logic [3:0] dev_cnt_r, ext_cnt_r;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// a frame starts at a low seen while idle
	assign dev_go = !dev_in_r && !dev_txd;
	assign ext_go = !ext_in_r && !ext_txd;
	// frame position trackers; a stop bit stretched by the sender is fine
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dev_in_r <= 1'b0;
			ext_in_r <= 1'b0;
			dev_cyc_r <= 16'h0000;
			ext_cyc_r <= 16'h0000;
		end
		else
		begin
			dev_in_r <= dev_go || (dev_in_r && dev_cyc_r != LAST);
			ext_in_r <= ext_go || (ext_in_r && ext_cyc_r != LAST);
			dev_cyc_r <= dev_go ? 16'h0001 : dev_cyc_r + 16'h0001;
			ext_cyc_r <= ext_go ? 16'h0001 : ext_cyc_r + 16'h0001;
		end
	end
	// frames started while the other end asks for a stop
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dev_cnt_r <= 4'h0;
			ext_cnt_r <= 4'h0;
		end
		else
		begin
			dev_cnt_r <= !cts_n ? 4'h0 : dev_cnt_r + 4'(dev_go);
			ext_cnt_r <= !rts_n ? 4'h0 : ext_cnt_r + 4'(ext_go);
		end
	end
	AST_RST_IDLE:
	assert property ($rose(rst_n) |-> dev_txd && ext_txd && !rts_n)
		else $error("link not idle after reset");
	AST_DEV_START_LOW:
	assert property (dev_go |-> (!dev_txd) [*8])
		else $error("device start bit too short");
	AST_DEV_BIT_STEADY:
	assert property (dev_in_r && dev_cyc_r % BITW != 16'h0 |-> $stable(dev_txd))
		else $error("device line moved inside a bit");
	AST_DEV_STOP_HIGH:
	assert property (dev_in_r && dev_cyc_r == MID_STOP |-> dev_txd)
		else $error("device stop bit low");
	AST_EXT_START_LOW:
	assert property (ext_go |-> (!ext_txd) [*8])
		else $error("far end start bit too short");
	AST_EXT_STOP_HIGH:
	assert property (ext_in_r && ext_cyc_r == MID_STOP |-> ext_txd)
		else $error("far end stop bit low");
	AST_CTS_LIMIT:
	assert property (cts_n |-> dev_cnt_r <= 4'h2)
		else $error("device sent too many bytes after stop request");
	AST_RTS_OBEY:
	assert property (rts_n |-> ext_cnt_r <= 4'h1)
		else $error("far end kept sending after rts rose");
endmodule : ufc_chk

// ### sim/tb_top.sv
// tb_top: self-checking bench for the device and far-end uart pair.
// assumes both ends share ref_clk; the bench plays software and far user.
module tb_top import ufc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BIT = 8;
	localparam int LIMIT = 100000;
	logic ref_clk, rst_n, wr, rd, sw_en, near_full, tx_valid, tx_ready;
	logic rx_valid, held;
	logic [7:0] addr, tx_data, rx_data, seq, exp_b;
	logic [31:0] wdata, rdata, d;
	logic [7:0] q[$];
	int error_cnt, tests_run, cyc;
	ufc_link_if link ();
	ufc_dev ufc_dev_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link.dev),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	ufc_ext ufc_ext_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link.ext),
		.hw_en(1'b1), .sw_en(sw_en), .xon_ch(8'h5a), .xoff_ch(8'ha5),
		.div(20'(BIT)), .near_full(near_full), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
		.rx_valid(rx_valid), .held(held));
	ufc_chk #(.BIT(BIT)) ufc_chk_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.dev_txd(link.dev_txd), .ext_txd(link.ext_txd), .rts_n(link.rts_n),
		.cts_n(link.cts_n));
	// free-running 100 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// collect far-end bytes and cut a hang short
	always @(posedge ref_clk)
	begin
		cyc++;
		if (rx_valid === 1'b1)
			q.push_back(rx_data);
		if (cyc == LIMIT)
		begin
			error_cnt++;
			$display("mismatch run_cycles expected %0d seen %0d", LIMIT - 1, cyc);
			stop_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask : wr_reg
	// read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
	task automatic bits(input int n);
		repeat (n * BIT) @(posedge ref_clk);
	endtask : bits
	// offer one byte on the far end; held until the end takes it
	task automatic send_ext(input logic [7:0] b);
		@(posedge ref_clk);
		tx_data <= b;
		tx_valid <= 1'b1;
		@(negedge ref_clk);
		while (tx_ready !== 1'b1)
			@(negedge ref_clk);
		@(posedge ref_clk);
		tx_valid <= 1'b0;
	endtask : send_ext
	task automatic send_seq(input int n);
		repeat (n)
		begin
			send_ext(seq);
			seq++;
		end
	endtask : send_seq
	task automatic pop(input int n);
		repeat (n)
		begin
			rd_reg(OFS_RXDATA);
			chk("rx_byte", {23'h0, 1'b1, exp_b}, {23'h0, d[8:0]});
			exp_b++;
		end
	endtask : pop
	// status masked to rts and receive level
	task automatic chk_st(input string n, input logic [31:0] e);
		rd_reg(OFS_STATUS);
		chk(n, e, d & 32'h040003ff);
	endtask : chk_st
	task automatic chk_q(input string n, input int k, input logic [7:0] b);
		chk(n, 32'(k), 32'(q.size()));
		if (k > 0)
			chk(n, {24'h0, b}, {24'h0, q[k-1]});
	endtask : chk_q
	task automatic t_reset();
		logic [7:0] a [7] = '{OFS_CTRL, OFS_CHARS, OFS_LIMITS, OFS_BAUD, 8'h20,
			OFS_RXDATA, OFS_STATUS};
		logic [31:0] e [7] = '{32'h0, 32'h00001311, 32'h00400180,
			32'(DIV_RST), 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 7; i++)
		begin
			rd_reg(a[i]);
			chk("reg_reset", e[i], d);
		end
		wr_reg(OFS_BAUD, 32'(BIT));
		$display("test reset done");
	endtask : t_reset
	// fill to the stop level, check hysteresis, then drain
	task automatic t_hw(input logic [31:0] lim, input int stop, input int res);
		wr_reg(OFS_LIMITS, lim);
		wr_reg(OFS_CTRL, 32'h1);
		send_seq(stop - 1);
		bits(12);
		chk_st("below_stop", 32'(stop - 1));
		send_seq(1);
		bits(12);
		wr_reg(OFS_CTRL, 32'h0);
		chk_st("hw_off", 32'(stop));
		wr_reg(OFS_CTRL, 32'h1);
		chk_st("at_stop", 32'h04000000 | 32'(stop));
		pop(stop - res - 1);
		chk_st("hold", 32'h04000000 | 32'(res + 1));
		pop(1);
		repeat (2) @(posedge ref_clk);
		chk_st("resume", 32'(res));
		pop(res);
		$display("test hw flow %0d done", stop);
	endtask : t_hw
	task automatic t_cts();
		q.delete();
		wr_reg(OFS_TXDATA, 32'hc1);
		wr_reg(OFS_TXDATA, 32'hc2);
		wr_reg(OFS_TXDATA, 32'hc3);
		// the first byte has already started; a data edge is no start mark
		while (link.dev_txd !== 1'b0)
			@(posedge ref_clk);
		@(posedge ref_clk);
		near_full <= 1'b1;
		bits(40);
		chk_q("cts_stop", 1, 8'hc1);
		near_full <= 1'b0;
		bits(25);
		chk_q("cts_go", 3, 8'hc3);
		$display("test cts done");
	endtask : t_cts
	task automatic t_imm();
		q.delete();
		wr_reg(OFS_TXDATA, 32'ha0);
		wr_reg(OFS_TXDATA, 32'ha1);
		wr_reg(OFS_IMM, 32'he5);
		bits(40);
		chk_q("imm", 3, 8'ha1);
		chk("imm_order", 32'he5, {24'h0, q[1]});
		$display("test immediate done");
	endtask : t_imm
	task automatic t_sw();
		wr_reg(OFS_CHARS, 32'h0000a55a);
		wr_reg(OFS_LIMITS, 32'h01f80004);
		wr_reg(OFS_CTRL, 32'h2);
		q.delete();
		send_ext(8'ha5);
		bits(12);
		rd_reg(OFS_STATUS);
		chk("halted", 32'h1, {31'h0, d[27]});
		send_seq(8);
		bits(25);
		chk("own_xoff_held", 32'h0, {31'h0, held});
		wr_reg(OFS_TXDATA, 32'h3c);
		wr_reg(OFS_CTRL, 32'h6);
		bits(25);
		chk("pass_xoff", 32'h1, {31'h0, held});
		chk_q("pass_only_flow", 1, 8'ha5);
		sw_en <= 1'b0;
		send_ext(8'h5a);
		bits(25);
		chk_q("xon_resume", 2, 8'h3c);
		pop(8);
		bits(25);
		send_ext(8'ha5);
		bits(12);
		q.delete();
		wr_reg(OFS_TXDATA, 32'h77);
		bits(25);
		chk_q("halt_again", 0, 8'h00);
		wr_reg(OFS_CTRL, 32'h0);
		bits(25);
		chk_q("sw_off", 1, 8'h77);
		$display("test sw flow done");
	endtask : t_sw
	task automatic t_txrts();
		wr_reg(OFS_CTRL, 32'h8);
		bits(1);
		chk("rts_idle", 32'h1, {31'h0, link.rts_n});
		wr_reg(OFS_TXDATA, 32'h42);
		@(negedge link.dev_txd);
		@(posedge ref_clk);
		#1 chk("rts_send", 32'h0, {31'h0, link.rts_n});
		bits(11);
		chk("rts_after", 32'h1, {31'h0, link.rts_n});
		wr_reg(OFS_BAUD, 32'(DIV_LOW) + 32'h1);
		bits(1);
		chk("rts_slow", 32'h0, {31'h0, link.rts_n});
		$display("test tx rts done");
	endtask : t_txrts
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test
	// main sequence
	initial
	begin
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		sw_en = 1'b1;
		near_full = 1'b0;
		tx_valid = 1'b0;
		addr = 8'h00;
		tx_data = 8'h00;
		wdata = 32'h0;
		seq = 8'h00;
		exp_b = 8'h00;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_hw(32'h01f80004, 8, 4);
		t_hw(32'h01f40014, 12, 11);
		t_hw(32'h00400258, 448, 192);
		t_hw(32'h00000064, 448, 100);
		t_cts();
		t_imm();
		t_sw();
		t_txrts();
		stop_test();
	end
endmodule : tb_top
